// ---- src/msc_defs.svh ----
// Register offsets, field positions and reset values for the step config bank
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

`define MSC_ADDR_W        8
`define MSC_DATA_W        16
`define MSC_OFF_STEP7     8'h97
`define MSC_OFF_STEP8     8'h98
`define MSC_RST_STEP7     16'h0007
`define MSC_RST_STEP8     16'h0008
`define MSC_BIT_EN        15
`define MSC_GAIN_HI       14
`define MSC_GAIN_LO       13
`define MSC_BIT_NEG       4
`define MSC_POS_HI        3
`define MSC_POS_LO        0
`define MSC_WR_MASK       16'hE01F
`define MSC_POS_INTERNAL  4'h8
`define MSC_POS_SHORT     4'h9
`define MSC_POS_TDAC      4'hA
`define MSC_POS_ANALOG_POWER_RAIL      4'hE
`define MSC_POS_DIGITAL_POWER_RAIL      4'hF

`endif

// ---- src/msc_pkg.sv ----
// Types shared by the step configuration bank
`default_nettype none
package msc_pkg;
	// Decoded converter gain
	typedef enum logic [1:0] {
		MSC_GAIN_X1 = 2'b00,
		MSC_GAIN_X2 = 2'b01,
		MSC_GAIN_X4 = 2'b10
	} msc_gain_t;

	// Negative input source
	typedef enum logic [1:0] {
		MSC_NEG_GND  = 2'b00,
		MSC_NEG_CH7  = 2'b01,
		MSC_NEG_AUTO = 2'b10
	} msc_neg_t;

	// Register access state
	typedef enum logic [1:0] {
		MSC_ST_IDLE  = 2'b00,
		MSC_ST_WRITE = 2'b01,
		MSC_ST_READ  = 2'b10
	} msc_state_t;
endpackage : msc_pkg
`default_nettype wire

// ---- src/msc_step_reg.sv ----
// One 16-bit step configuration register with writable field mask
`timescale 1ns/1ps
`default_nettype none
`include "msc_defs.svh"
module msc_step_reg
	import msc_pkg::*;
#(
	parameter logic [15:0] RST_VAL = `MSC_RST_STEP7
)(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// Write port
	input  wire logic        i_we,
	input  wire logic [15:0] i_wdata,
	// Stored value
	output logic      [15:0] o_value
);
	logic [15:0] value_q;

	// Reserved bits are never stored, so they read zero
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			value_q <= RST_VAL;
		else if (i_we)
			value_q <= i_wdata & `MSC_WR_MASK;
	end

	assign o_value = value_q;
endmodule : msc_step_reg
`default_nettype wire

// ---- src/msc_step_decode.sv ----
// Decode of one step's fields into converter settings
`timescale 1ns/1ps
`default_nettype none
`include "msc_defs.svh"
module msc_step_decode
	import msc_pkg::*;
(
	// Register value
	input  wire logic [15:0] i_value,
	// Decoded settings
	output logic             o_include,
	output msc_gain_t        o_gain,
	output logic [3:0]       o_pos_sel,
	output msc_neg_t         o_neg_src
);
	logic [1:0] gain_field;
	logic [3:0] pos_field;

	assign gain_field = i_value[`MSC_GAIN_HI:`MSC_GAIN_LO];
	assign pos_field  = i_value[`MSC_POS_HI:`MSC_POS_LO];
	assign o_include  = i_value[`MSC_BIT_EN];
	assign o_pos_sel  = pos_field;

	// Gain: 10b and 11b both give gain 4
	always_comb
	begin
		case (gain_field)
			2'b00:   o_gain = MSC_GAIN_X1;
			2'b01:   o_gain = MSC_GAIN_X2;
			default: o_gain = MSC_GAIN_X4;
		endcase
	end

	// Internal sources pick their own negative input
	always_comb
	begin
		if (pos_field >= `MSC_POS_INTERNAL)
			o_neg_src = MSC_NEG_AUTO;
		else if (i_value[`MSC_BIT_NEG])
			o_neg_src = MSC_NEG_CH7;
		else
			o_neg_src = MSC_NEG_GND;
	end
endmodule : msc_step_decode
`default_nettype wire

// ---- src/msc_bank.sv ----
// Step 7 and step 8 configuration registers of the converter sequencer
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "msc_defs.svh"
module msc_bank
	import msc_pkg::*;
(
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rstn,
	// Register port
	input  wire logic [`MSC_ADDR_W-1:0] i_addr,
	input  wire logic [`MSC_DATA_W-1:0] i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [`MSC_DATA_W-1:0] o_rdata,
	// Step 7 settings
	output logic                        o_s7_include,
	output msc_gain_t                   o_s7_gain,
	output logic      [3:0]             o_s7_pos_sel,
	output msc_neg_t                    o_s7_neg_src,
	// Step 8 settings
	output logic                        o_s8_include,
	output msc_gain_t                   o_s8_gain,
	output logic      [3:0]             o_s8_pos_sel,
	output msc_neg_t                    o_s8_neg_src
);
	////////////////////////////////////////////////////////////////////////
	logic [15:0] s7_value;
	logic [15:0] s8_value;
	logic        s7_we;
	logic        s8_we;
	logic        s7_inc_c;
	logic        s8_inc_c;
	msc_gain_t   s7_gain_c;
	msc_gain_t   s8_gain_c;
	logic [3:0]  s7_pos_c;
	logic [3:0]  s8_pos_c;
	msc_neg_t    s7_neg_c;
	msc_neg_t    s8_neg_c;
	logic [15:0] rdata_d;

	// Reset words as constants, so their fields can be sliced
	localparam logic [15:0] RST7 = `MSC_RST_STEP7;
	localparam logic [15:0] RST8 = `MSC_RST_STEP8;

	// Address decode of the write strobe
	assign s7_we = i_wr && (i_addr == `MSC_OFF_STEP7);
	assign s8_we = i_wr && (i_addr == `MSC_OFF_STEP8);

	////////////////////////////////////////////////////////////////////////
	// Storage
	msc_step_reg #(.RST_VAL(`MSC_RST_STEP7)) u_s7 (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_we    (s7_we),
		.i_wdata (i_wdata),
		.o_value (s7_value)
	);
	msc_step_reg #(.RST_VAL(`MSC_RST_STEP8)) u_s8 (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_we    (s8_we),
		.i_wdata (i_wdata),
		.o_value (s8_value)
	);

	// Field decode
	msc_step_decode u_d7 (
		.i_value   (s7_value),
		.o_include (s7_inc_c),
		.o_gain    (s7_gain_c),
		.o_pos_sel (s7_pos_c),
		.o_neg_src (s7_neg_c)
	);
	msc_step_decode u_d8 (
		.i_value   (s8_value),
		.o_include (s8_inc_c),
		.o_gain    (s8_gain_c),
		.o_pos_sel (s8_pos_c),
		.o_neg_src (s8_neg_c)
	);

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read zero
	always_comb
	begin
		case (i_addr)
			`MSC_OFF_STEP7: rdata_d = s7_value;
			`MSC_OFF_STEP8: rdata_d = s8_value;
			default:        rdata_d = 16'h0000;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_rdata <= 16'h0000;
		else if (i_rd)
			o_rdata <= rdata_d;
		else
			o_rdata <= 16'h0000;
	end

	// Registered step settings, reset to decoded reset values
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_s7_include <= 1'b0;
			o_s7_gain    <= MSC_GAIN_X1;
			o_s7_pos_sel <= RST7[`MSC_POS_HI:`MSC_POS_LO];
			o_s7_neg_src <= MSC_NEG_GND;
			o_s8_include <= 1'b0;
			o_s8_gain    <= MSC_GAIN_X1;
			o_s8_pos_sel <= RST8[`MSC_POS_HI:`MSC_POS_LO];
			o_s8_neg_src <= MSC_NEG_AUTO;
		end
		else
		begin
			o_s7_include <= s7_inc_c;
			o_s7_gain    <= s7_gain_c;
			o_s7_pos_sel <= s7_pos_c;
			o_s7_neg_src <= s7_neg_c;
			o_s8_include <= s8_inc_c;
			o_s8_gain    <= s8_gain_c;
			o_s8_pos_sel <= s8_pos_c;
			o_s8_neg_src <= s8_neg_c;
		end
	end
endmodule : msc_bank
`default_nettype wire

// ---- verification/msc_bank_props.sv ----
// Port assertions for the step configuration bank
`timescale 1ns/1ps
`default_nettype none
module msc_bank_props
	import msc_pkg::*;
(
	// Observed ports
	input wire logic        i_clk,
	input wire logic        i_rstn,
	input wire logic [7:0]  i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic        o_s7_include,
	input wire msc_gain_t   o_s7_gain,
	input wire logic [3:0]  o_s7_pos_sel,
	input wire msc_neg_t    o_s7_neg_src
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// Step 7 write and unmapped read
	wire logic w7 = i_wr && (i_addr == 8'h97);
	wire logic rx = i_rd && (i_addr != 8'h97) && (i_addr != 8'h98);
	AST_RSVD: assert property (i_rd |=> o_rdata[12:5] == 8'h00)
		else $error("reserved bits nonzero");
	AST_UNMAP: assert property (rx |=> o_rdata == 16'h0000)
		else $error("unmapped read nonzero");
	AST_EN: assert property (w7 |-> ##2
		o_s7_include == $past(i_wdata[15], 2))
		else $error("include flag wrong");
	AST_GAIN4: assert property (w7 && i_wdata[14] |-> ##2
		o_s7_gain == MSC_GAIN_X4)
		else $error("gain four wrong");
	AST_GAINL: assert property (w7 && !i_wdata[14] |-> ##2
		o_s7_gain == $past(i_wdata[14:13], 2))
		else $error("gain low wrong");
	AST_POS: assert property (w7 |-> ##2
		o_s7_pos_sel == $past(i_wdata[3:0], 2))
		else $error("positive select wrong");
	AST_AUTO: assert property (w7 && i_wdata[3] |-> ##2
		o_s7_neg_src == MSC_NEG_AUTO)
		else $error("negative not automatic");
	AST_NEG: assert property (w7 && !i_wdata[3] |-> ##2
		o_s7_neg_src == {1'b0, $past(i_wdata[4], 2)})
		else $error("negative select wrong");
	// Main scenarios reached
	C_AUTO: cover property (w7 && i_wdata[3]);
	C_MAN: cover property (w7 && !i_wdata[3]);
	C_UNMAP: cover property (rx);
endmodule : msc_bank_props
bind msc_bank msc_bank_props u_props (.*);
`default_nettype wire

// ---- verification/mux_adc_step_config_bench.sv ----
// Self-checking bench for the step configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
	mismatches++; $display("ERROR %0t got %h", $time, g); end end
module mux_adc_step_config_bench
	import msc_pkg::*;
	;
	logic        i_clk;
	logic        i_rstn;
	logic [7:0]  i_addr;
	logic [15:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [15:0] o_rdata;
	logic        o_s7_include, o_s8_include;
	msc_gain_t   o_s7_gain, o_s8_gain;
	logic [3:0]  o_s7_pos_sel, o_s8_pos_sel;
	msc_neg_t    o_s7_neg_src, o_s8_neg_src;
	int          mismatches, tests_run;
	msc_bank dut (
		.i_clk        (i_clk),
		.i_rstn       (i_rstn),
		.i_addr       (i_addr),
		.i_wdata      (i_wdata),
		.i_wr         (i_wr),
		.i_rd         (i_rd),
		.o_rdata      (o_rdata),
		.o_s7_include (o_s7_include),
		.o_s7_gain    (o_s7_gain),
		.o_s7_pos_sel (o_s7_pos_sel),
		.o_s7_neg_src (o_s7_neg_src),
		.o_s8_include (o_s8_include),
		.o_s8_gain    (o_s8_gain),
		.o_s8_pos_sel (o_s8_pos_sel),
		.o_s8_neg_src (o_s8_neg_src)
	);
	// Write, then wait for settings to update
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		repeat (2) @(negedge i_clk);
	endtask : wr
	// Read, data checked in the following cycle
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		`CHK(o_rdata, e)
	endtask : rd
	task automatic complete_run;
		$display("tests %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	////////////////////////////////////////
	initial
	begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	// Hang guard
	initial
	begin
		repeat (2000) @(posedge i_clk);
		mismatches++;
		complete_run();
	end
	initial
	begin
		{i_rstn, i_wr, i_rd, i_addr, i_wdata} = '0;
		repeat (6) @(posedge i_clk);
		i_rstn <= 1'b1;
		`CHK(o_s7_include, 1'b0)
		`CHK(o_s7_gain, MSC_GAIN_X1)
		`CHK(o_s7_pos_sel, 4'h7)
		`CHK(o_s7_neg_src, MSC_NEG_GND)
		`CHK(o_s8_include, 1'b0)
		`CHK(o_s8_pos_sel, 4'h8)
		`CHK(o_s8_neg_src, MSC_NEG_AUTO)
		rd(8'h97, 16'h0007);
		rd(8'h98, 16'h0008);
		$display("reset test done");
		wr(8'h99, 16'h1234);
		rd(8'h99, 16'h0000);
		wr(8'h98, 16'hBFF9);
		rd(8'h98, 16'hA019);
		`CHK(o_s8_include, 1'b1)
		`CHK(o_s8_gain, MSC_GAIN_X2)
		`CHK(o_s8_pos_sel, 4'h9)
		`CHK(o_s8_neg_src, MSC_NEG_AUTO)
		$display("access test done");
		for (int c = 0; c < 16; c++)
		begin
			wr(8'h97, {c[0], c[1:0], 8'h00, c[2], c[3:0]});
			`CHK(o_s7_include, c[0])
			`CHK(o_s7_gain, c[1] ? MSC_GAIN_X4 : msc_gain_t'({1'b0, c[0]}))
			`CHK(o_s7_pos_sel, c[3:0])
			`CHK(o_s7_neg_src, c[3] ? MSC_NEG_AUTO : msc_neg_t'({1'b0, c[2]}))
		end
		wr(8'h97, 16'hFFFF);
		rd(8'h97, 16'hE01F);
		$display("field test done");
		complete_run();
	end
endmodule : mux_adc_step_config_bench
`default_nettype wire
